//--- rtl/mih_pkg.sv
// Package for the microphone insert and hook switch detector.
// Holds the register map, field positions, reset values and sample timing.
// Assumes a 200 MHz clock and a byte-addressed register port with registers four addresses apart.
package mih_pkg;

    localparam int CLK_PERIOD_NS = 5;
    // Comparator sampling period and the delays built from it.
    localparam int SAMPLE_PERIOD_NS = 1000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int INSERT_DETECT_DELAY_NS = 100000;
    localparam logic [7:0] INSERT_DELAY_SAMPLES = 8'(INSERT_DETECT_DELAY_NS / SAMPLE_PERIOD_NS);
    localparam logic [7:0] HOOK_RUN_SAMPLES = 8'h0A;
    localparam logic [7:0] HOOK_DB_SAMPLES = 8'h14;
    localparam logic [7:0] INSERT_RUN_SAMPLES = 8'h01;
    localparam logic [7:0] INSERT_DB_SAMPLES = 8'h08;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;

    // Control register fields.
    localparam int CTRL_MIC_POL = 0;
    localparam int CTRL_HOOK_POL = 1;
    localparam int CTRL_MIC_DB = 2;
    localparam int CTRL_HOOK_DB = 3;
    localparam int CTRL_GPIO_SEL = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // Status, clear, enable and state registers share this layout.
    localparam int EVT_MIC = 0;
    localparam int EVT_HOOK = 1;
    localparam int EVT_W = 2;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } mih_busreq_t;

endpackage

//--- rtl/mih_run_filter.sv
// Consecutive-sample filter: the output follows the input only after a run
// of 'need' equal samples. Assumes level is already synchronised to clock.
`timescale 1ns/1ps
module mih_run_filter (
    input wire logic clock,
    input wire logic rst,
    input wire logic sampleTick,
    input wire logic level,
    input wire logic [7:0] need,
    output logic filtered
);
    logic [7:0] runCnt_r;

    // A single differing sample restarts the run, so bounce shorter than 'need' samples never leaks through.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            runCnt_r <= 8'h00;
            filtered <= 1'b0;
        end
        else if (sampleTick)
        begin
            if (level == filtered)
                runCnt_r <= 8'h00;
            else if (runCnt_r + 8'h01 >= need)
            begin
                runCnt_r <= 8'h00;
                filtered <= level;
            end
            else
                runCnt_r <= runCnt_r + 8'h01;
        end
    end

    chk_change_on_tick: assert property (@(posedge clock) disable iff (rst)
        $changed(filtered) |-> $past(sampleTick) && $past(runCnt_r) + 8'h01 >= $past(need))
        else $error("Filter output changed without a full run of samples.");

endmodule

//--- rtl/mih_detect.sv
// Microphone insert and hook switch detector with sticky interrupt flags.
// Assumes the two comparator inputs are asynchronous levels from the bias
// current sensing, and a host on the same clock using the register port.
//
// Functional notes
// R01: Host clears mic insert polarity to 0 before insertion is expected.
// R02: Insert detection uses a longer debounce run when its enable is 1.
// R03: Hook press flagged only after 10 consecutive samples above threshold.
// R04: Hook release flagged only after 10 consecutive samples below threshold.
// R05: Hook detection uses a longer debounce run when its enable is 1.
// R06: After insertion host sets insert polarity 1, then clears the flag.
// R07: With the mic inserted, host sets hook polarity to 0.
// R08: On hook press host sets hook polarity 1, then clears the flag.
// R09: On hook release host sets hook polarity 0, then clears the flag.
// R10: On removal host sets insert polarity 0, then clears the flag.
// R11: Host polls the interrupt status register at every stage.
// R12: Pin output shows steady insert or hook state, after detect delays.
// R13: Flags stay set until cleared; polarity changes never clear them.
`timescale 1ns/1ps
module mih_detect
    import mih_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic micInsertRaw,
    input wire logic hookPressRaw,
    input wire mih_pkg::mih_busreq_t busReq,
    output logic [15:0] rdData_r,
    output logic irq_r,
    output logic detectPin_r
);
    import mih_pkg::*;

    logic [1:0] insSync_r;
    logic [1:0] hookSync_r;
    logic [7:0] tickCnt_r;
    logic sampleTick_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [EVT_W-1:0] status_r;
    logic [EVT_W-1:0] status_nxt;
    logic [EVT_W-1:0] irqEn_r;
    logic [EVT_W-1:0] trig_r;
    logic [EVT_W-1:0] trig;
    logic [EVT_W-1:0] event_w;
    logic [EVT_W-1:0] clearReq;
    logic [7:0] insNeed;
    logic [7:0] hookNeed;
    logic insState;
    logic hookState;
    logic insSteady;
    logic hookLast_r;
    logic [7:0] hookRun_r;
    logic insLast_r;
    logic [7:0] insRun_r;

    // Two flops on each comparator level; only the second flop is read.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            insSync_r <= 2'h0;
            hookSync_r <= 2'h0;
        end
        else
        begin
            insSync_r <= {insSync_r[0], micInsertRaw};
            hookSync_r <= {hookSync_r[0], hookPressRaw};
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tickCnt_r <= 8'h00;
            sampleTick_r <= 1'b0;
        end
        else if (tickCnt_r == 8'(SAMPLE_CYCLES - 1))
        begin
            tickCnt_r <= 8'h00;
            sampleTick_r <= 1'b1;
        end
        else
        begin
            tickCnt_r <= tickCnt_r + 8'h01;
            sampleTick_r <= 1'b0;
        end
    end

    assign insNeed = ctrl_r[CTRL_MIC_DB] ? INSERT_DB_SAMPLES : INSERT_RUN_SAMPLES; // [R02]
    assign hookNeed = ctrl_r[CTRL_HOOK_DB] ? HOOK_DB_SAMPLES : HOOK_RUN_SAMPLES; // [R03] [R04] [R05]

    mih_run_filter u_insFilter (
        .clock(clock),
        .rst(rst),
        .sampleTick(sampleTick_r),
        .level(insSync_r[1]),
        .need(insNeed),
        .filtered(insState)
    );

    mih_run_filter u_hookFilter (
        .clock(clock),
        .rst(rst),
        .sampleTick(sampleTick_r),
        .level(hookSync_r[1]),
        .need(hookNeed),
        .filtered(hookState)
    );

    // The pin view of insertion waits the full insert detect delay.
    mih_run_filter u_insSteady (
        .clock(clock),
        .rst(rst),
        .sampleTick(sampleTick_r),
        .level(insState),
        .need(INSERT_DELAY_SAMPLES),
        .filtered(insSteady)
    );

    // A flag is raised when the state moves away from what the polarity
    // expects. Polarity only steers this trigger; it can raise a flag but never clears one.
    assign trig[EVT_MIC] = insState ^ ctrl_r[CTRL_MIC_POL];
    assign trig[EVT_HOOK] = hookState ^ ctrl_r[CTRL_HOOK_POL];
    assign event_w = trig & ~trig_r;
    assign clearReq = (busReq.wr && busReq.addr == ADDR_CLEAR) ? busReq.wdata[EVT_W-1:0] : 2'h0;
    assign status_nxt = (status_r & ~clearReq) | event_w; // [R13]

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            trig_r <= EVT_RESET;
            status_r <= EVT_RESET;
        end
        else
        begin
            trig_r <= trig;
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RESET;
            irqEn_r <= EVT_RESET;
        end
        else if (busReq.wr)
        begin
            if (busReq.addr == ADDR_CTRL)
                ctrl_r <= busReq.wdata[CTRL_W-1:0];
            if (busReq.addr == ADDR_IRQ_EN)
                irqEn_r <= busReq.wdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            rdData_r <= 16'h0000;
        else if (busReq.rd)
        begin
            unique case (busReq.addr)
                ADDR_CTRL: rdData_r <= {11'h000, ctrl_r};
                ADDR_STATUS: rdData_r <= {14'h0000, status_r};
                ADDR_IRQ_EN: rdData_r <= {14'h0000, irqEn_r};
                ADDR_STATE: rdData_r <= {14'h0000, hookState, insState};
                default: rdData_r <= 16'h0000;
            endcase
        end
        else
            rdData_r <= 16'h0000;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(status_nxt & irqEn_r);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            detectPin_r <= 1'b0;
        else
            detectPin_r <= ctrl_r[CTRL_GPIO_SEL] ? hookState : insSteady; // [R12]
    end

    // Independent count of equal samples in a row. The run checks below use it so
    // that they do not lean on the filters they guard.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hookLast_r <= 1'b0;
            hookRun_r <= 8'h00;
            insLast_r <= 1'b0;
            insRun_r <= 8'h00;
        end
        else if (sampleTick_r)
        begin
            hookLast_r <= hookSync_r[1];
            insLast_r <= insSync_r[1];
            if (hookSync_r[1] != hookLast_r)
                hookRun_r <= 8'h01;
            else if (hookRun_r != 8'hFF)
                hookRun_r <= hookRun_r + 8'h01;
            if (insSync_r[1] != insLast_r)
                insRun_r <= 8'h01;
            else if (insRun_r != 8'hFF)
                insRun_r <= insRun_r + 8'h01;
        end
    end

    chk_flag_sticky: assert property (@(posedge clock) disable iff (rst) // [R13]
        status_r[EVT_MIC] && !(busReq.wr && busReq.addr == ADDR_CLEAR && busReq.wdata[0])
        |=> status_r[EVT_MIC])
        else $error("Insert flag dropped without a clear.");

    chk_set_wins: assert property (@(posedge clock) disable iff (rst) // [R13]
        event_w[EVT_HOOK] |=> status_r[EVT_HOOK])
        else $error("Hook event lost against a clear.");

    chk_pol_keeps_flag: assert property (@(posedge clock) disable iff (rst) // [R13]
        busReq.wr && busReq.addr == ADDR_CTRL && status_r[EVT_HOOK] |=> status_r[EVT_HOOK])
        else $error("Polarity write cleared a pending hook flag.");

    chk_hook_run: assert property (@(posedge clock) disable iff (rst) // [R03]
        $rose(hookState) |-> hookLast_r && hookRun_r >= HOOK_RUN_SAMPLES)
        else $error("Hook press accepted on fewer than ten samples.");

    chk_hook_release: assert property (@(posedge clock) disable iff (rst) // [R04]
        $fell(hookState) |-> !hookLast_r && hookRun_r >= HOOK_RUN_SAMPLES)
        else $error("Hook release accepted on fewer than ten samples.");

    chk_insert_debounce: assert property (@(posedge clock) disable iff (rst) // [R02]
        $changed(insState) && $past(ctrl_r[CTRL_MIC_DB]) |-> insRun_r >= INSERT_DB_SAMPLES)
        else $error("Insert debounce enable not applied.");

    chk_hook_debounce: assert property (@(posedge clock) disable iff (rst) // [R05]
        $changed(hookState) && $past(ctrl_r[CTRL_HOOK_DB]) |-> hookRun_r >= HOOK_DB_SAMPLES)
        else $error("Hook debounce enable not applied.");

    chk_pin_source: assert property (@(posedge clock) disable iff (rst) // [R12]
        !ctrl_r[CTRL_GPIO_SEL] && $stable(ctrl_r) |=> detectPin_r == $past(insSteady))
        else $error("Detect pin does not follow the steady insert state.");

    chk_irq_level: assert property (@(posedge clock) disable iff (rst)
        ##1 irq_r == |(status_r & $past(irqEn_r)))
        else $error("Interrupt output does not track enabled flags.");

endmodule

//--- test/mih_jack_model.sv
// Model of the jack and hook switch as seen through the two bias comparators.
// Assumes the bench commands each level and how long it is held.
`timescale 1ns/1ps
module mih_jack_model (
    input wire logic clock,
    output logic micInsertRaw,
    output logic hookPressRaw
);
    initial
    begin
        micInsertRaw = 1'b0;
        hookPressRaw = 1'b0;
    end
    // Contacts move just after an edge, with no relation to the sample tick.
    task automatic hold(input logic ins, input logic hook, input int cycles);
        @(posedge clock);
        micInsertRaw <= ins;
        hookPressRaw <= hook;
        repeat (cycles) @(posedge clock);
    endtask
endmodule

//--- test/mih_detect_test.sv
// Self-checking bench for the insert and hook detector.
// Assumes the jack model in its own file and a host on the register port.
`timescale 1ns/1ps
module mih_detect_test;
    import mih_pkg::*;
    localparam int SC = SAMPLE_CYCLES;
    logic clock;
    logic rst;
    logic micInsertRaw;
    logic hookPressRaw;
    mih_busreq_t busReq;
    logic [15:0] rdData_r;
    logic irq_r;
    logic detectPin_r;
    int failCount = 0;
    int checksDone = 0;
    int cycleCount = 0;
    mih_jack_model jack (.clock(clock), .micInsertRaw(micInsertRaw), .hookPressRaw(hookPressRaw));
    mih_detect dut (
        .clock(clock),
        .rst(rst),
        .micInsertRaw(micInsertRaw),
        .hookPressRaw(hookPressRaw),
        .busReq(busReq),
        .rdData_r(rdData_r),
        .irq_r(irq_r),
        .detectPin_r(detectPin_r)
    );
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic endSim();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // The run needs about 43000 cycles; twice that means a hang.
    always @(posedge clock)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 90000)
        begin
            failCount = failCount + 1;
            endSim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            failCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        busReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        busReq.rd <= 1'b0;
        #1 chk(rdData_r, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic waitIrq(input int samples);
        int n;
        n = 0;
        #1;
        while (n < samples * SC && irq_r !== 1'b1)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chkBit(irq_r, 1'b1);
    endtask
    task automatic testRegs();
        rd(ADDR_CTRL, 16'h0000);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_IRQ_EN, 16'h0000);
        rd(ADDR_STATE, 16'h0000);
        wr(ADDR_CTRL, 16'h001F);
        rd(ADDR_CTRL, 16'h001F);
        @(posedge clock);
        #1 chk(rdData_r, 16'h0000);
        // Flipping both polarities with nothing attached raises both flags.
        rd(ADDR_STATUS, 16'h0003);
        wr(ADDR_CLEAR, 16'h0003);
        wr(ADDR_STATUS, 16'h0003);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_CLEAR, 16'h0000);
        rd(8'h20, 16'h0000);
        $display("test registers done");
    endtask
    task automatic testInsert();
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_IRQ_EN, 16'h0003);
        jack.hold(1'b1, 1'b0, 0);
        waitIrq(4);
        rd(ADDR_STATUS, 16'h0001);
        chkBit(detectPin_r, 1'b0);
        wr(ADDR_CTRL, 16'h0001);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_CLEAR, 16'h0001);
        rd(ADDR_STATUS, 16'h0000);
        settle();
        chkBit(irq_r, 1'b0);
        repeat (90 * SC) @(posedge clock);
        chkBit(detectPin_r, 1'b0);
        repeat (15 * SC) @(posedge clock);
        chkBit(detectPin_r, 1'b1);
        $display("test insert done");
    endtask
    task automatic testHook();
        wr(ADDR_CTRL, 16'h0011);
        jack.hold(1'b1, 1'b1, 8 * SC);
        jack.hold(1'b1, 1'b0, SC);
        jack.hold(1'b1, 1'b1, 8 * SC);
        rd(ADDR_STATUS, 16'h0000);
        waitIrq(4);
        rd(ADDR_STATUS, 16'h0002);
        settle();
        chkBit(detectPin_r, 1'b1);
        rd(ADDR_STATE, 16'h0003);
        wr(ADDR_IRQ_EN, 16'h0001);
        settle();
        chkBit(irq_r, 1'b0);
        wr(ADDR_IRQ_EN, 16'h0003);
        settle();
        chkBit(irq_r, 1'b1);
        wr(ADDR_CTRL, 16'h0013);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_CLEAR, 16'h0002);
        rd(ADDR_STATUS, 16'h0000);
        jack.hold(1'b1, 1'b0, 8 * SC);
        rd(ADDR_STATUS, 16'h0000);
        waitIrq(4);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_CTRL, 16'h0011);
        wr(ADDR_CLEAR, 16'h0002);
        rd(ADDR_STATUS, 16'h0000);
        $display("test hook done");
    endtask
    task automatic testDebounce();
        wr(ADDR_CTRL, 16'h000D);
        jack.hold(1'b0, 1'b0, 5 * SC);
        jack.hold(1'b1, 1'b0, 3 * SC);
        rd(ADDR_STATUS, 16'h0000);
        jack.hold(1'b1, 1'b1, 15 * SC);
        jack.hold(1'b1, 1'b0, 3 * SC);
        rd(ADDR_STATUS, 16'h0000);
        jack.hold(1'b1, 1'b1, 0);
        waitIrq(24);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_CLEAR, 16'h0002);
        jack.hold(1'b1, 1'b0, 22 * SC);
        rd(ADDR_STATE, 16'h0001);
        jack.hold(1'b0, 1'b0, 0);
        waitIrq(12);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_CTRL, 16'h000C);
        wr(ADDR_CLEAR, 16'h0001);
        rd(ADDR_STATUS, 16'h0000);
        $display("test debounce done");
    endtask
    task automatic testReset();
        wr(ADDR_CTRL, 16'h0001);
        settle();
        chkBit(irq_r, 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1 chkBit(irq_r, 1'b0);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_CTRL, 16'h0000);
        rd(ADDR_IRQ_EN, 16'h0000);
        chkBit(detectPin_r, 1'b0);
        $display("test reset done");
    endtask
    initial
    begin
        rst = 1'b1;
        busReq = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        testRegs();
        testInsert();
        testHook();
        testDebounce();
        testReset();
        endSim();
    end
endmodule
